// file: mcs_top.sv
// meter calibration sequencer with ahb-lite register slave
// What this block does
// - calibration mode accumulates products sixteen times smaller than normal energy
// - calibration accumulation starts only at the next rising voltage zero crossing
// - after the programmed periods, channel one's energy goes to its result register, channel two's only when selected (zero otherwise)
// - storing calibration results sets the calibration-ready flag
// - each product is multiplied by gain, scaled by two to minus fourteen, offset added
// - offset correction is added to every single voltage-current product
// - measurement mode writes each period's energy per channel, second when selected
// - each new per-period result sets zero-cross and sample-ready flags
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic signed [15:0] voltage_sample,
  input wire logic signed [15:0] current_sample_ch1,
  input wire logic signed [15:0] current_sample_ch2,
  output logic cal_ready_flag,
  output logic zero_cross_flag,
  output logic sample_ready_flag
);
  import mcs_pkg::*;

  // product scaled by gain, then per-product offset added
  function automatic logic signed [31:0] corr(input logic signed [15:0] v,
    input logic signed [15:0] i, input logic [15:0] g, input logic signed [31:0] off);
    logic signed [31:0] p;
    logic signed [48:0] s;
    p = v * i;
    s = (p * $signed({1'b0, g})) >>> GAIN_SHIFT;
    return s[31:0] + off;
  endfunction

  // bus registers
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q;
  logic [1:0] mode_q, mode_d;
  logic sel2_q, sel2_d;
  logic [15:0] gain_q [2];
  logic [15:0] gain_d [2];
  logic signed [31:0] poff_q [2];
  logic signed [31:0] poff_d [2];
  logic [15:0] calcnt_q, calcnt_d;
  logic [2:0] stat_q, stat_d;
  // engine state
  mcs_state_t state_q, state_d;
  logic [15:0] pcnt_q, pcnt_d;
  logic signed [31:0] acc_q [2];
  logic signed [31:0] acc_d [2];
  logic signed [31:0] ae_q [2];
  logic signed [31:0] ae_d [2];
  logic signed [31:0] pe_q [2];
  logic signed [31:0] pe_d [2];
  logic v_neg_q, v_neg_d;

  logic addr_ph;
  logic ctrl_wr;
  logic zc;
  logic cal_end;
  logic signed [31:0] c [2];
  logic [2:0] set_flags;
  logic [31:0] rd_val;

  assign addr_ph = hsel && hready && htrans == HTRANS_NONSEQ;
  assign ctrl_wr = wr_pend_q && wr_addr_q == ADDR_CTRL;
  // rising crossing: previous sample negative, this one not
  assign zc = sample_valid && v_neg_q && !voltage_sample[15];
  assign c[0] = corr(voltage_sample, current_sample_ch1, gain_q[0], poff_q[0]);
  assign c[1] = corr(voltage_sample, current_sample_ch2, gain_q[1], poff_q[1]);
  // a zero count is taken as one period so the run always ends
  assign cal_end = pcnt_q + CNT_ONE >= calcnt_q;

  always_comb
  begin
    case (haddr[ADDR_W-1:0])
      ADDR_CTRL: rd_val = {29'h0, sel2_q, mode_q};
      ADDR_STATUS: rd_val = {29'h0, stat_q};
      ADDR_GAIN1: rd_val = {16'h0, gain_q[0]};
      ADDR_GAIN2: rd_val = {16'h0, gain_q[1]};
      ADDR_POFF1: rd_val = poff_q[0];
      ADDR_POFF2: rd_val = poff_q[1];
      ADDR_CALCNT: rd_val = {16'h0, calcnt_q};
      ADDR_AE1: rd_val = ae_q[0];
      ADDR_AE2: rd_val = ae_q[1];
      ADDR_PE1: rd_val = pe_q[0];
      ADDR_PE2: rd_val = pe_q[1];
      ADDR_STATE: rd_val = {13'h0, state_q, pcnt_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    wr_pend_d = addr_ph && hwrite;
    wr_addr_d = haddr[ADDR_W-1:0];
    hrdata_d = (addr_ph && !hwrite) ? rd_val : 32'h0000_0000;
    mode_d = mode_q;
    sel2_d = sel2_q;
    gain_d = gain_q;
    poff_d = poff_q;
    calcnt_d = calcnt_q;
    stat_d = stat_q;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        ADDR_CTRL:
        begin
          mode_d = hwdata[CTRL_MODE_LSB +: 2];
          sel2_d = hwdata[CTRL_SEL_BIT];
        end
        ADDR_STATUS: stat_d = stat_q & ~hwdata[2:0];
        ADDR_GAIN1: gain_d[0] = hwdata[15:0];
        ADDR_GAIN2: gain_d[1] = hwdata[15:0];
        ADDR_POFF1: poff_d[0] = hwdata;
        ADDR_POFF2: poff_d[1] = hwdata;
        ADDR_CALCNT: calcnt_d = hwdata[15:0];
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle software clear
    stat_d = stat_d | set_flags;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
      mode_q <= MODE_OFF;
      sel2_q <= 1'b0;
      gain_q <= '{GAIN_RST, GAIN_RST};
      poff_q <= '{POFF_RST, POFF_RST};
      calcnt_q <= CALCNT_RST;
      stat_q <= 3'h0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      mode_q <= mode_d;
      sel2_q <= sel2_d;
      gain_q <= gain_d;
      poff_q <= poff_d;
      calcnt_q <= calcnt_d;
      stat_q <= stat_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    pcnt_d = pcnt_q;
    acc_d = acc_q;
    ae_d = ae_q;
    pe_d = pe_q;
    set_flags = 3'h0;
    v_neg_d = sample_valid ? voltage_sample[15] : v_neg_q;
    if (ctrl_wr)
    begin
      acc_d = '{32'h0, 32'h0};
      pcnt_d = 16'h0000;
      case (hwdata[CTRL_MODE_LSB +: 2])
        MODE_CAL: state_d = ST_CAL_WAIT;
        MODE_MEAS: state_d = ST_MEAS;
        default: state_d = ST_IDLE;
      endcase
    end
    else
    begin
      case (state_q)
        ST_CAL_WAIT:
          if (zc)
          begin
            state_d = ST_CAL_RUN;
            acc_d = c;
          end
        ST_CAL_RUN:
          if (zc && cal_end)
          begin
            state_d = ST_CAL_DONE;
            ae_d[0] = acc_q[0];
            ae_d[1] = sel2_q ? acc_q[1] : 32'h0;
            set_flags[STAT_CAL_READY_FLAG_BIT] = 1'b1;
          end
          else if (sample_valid)
          begin
            // raw scale, no meter-constant factor of sixteen
            acc_d[0] = acc_q[0] + c[0];
            acc_d[1] = acc_q[1] + c[1];
            if (zc)
              pcnt_d = pcnt_q + CNT_ONE;
          end
        ST_CAL_DONE: ;
        ST_MEAS:
          if (zc)
          begin
            pe_d[0] = acc_q[0] <<< NORM_SHIFT;
            if (sel2_q)
              pe_d[1] = acc_q[1] <<< NORM_SHIFT;
            set_flags[STAT_ZX_BIT] = 1'b1;
            set_flags[STAT_WFS_BIT] = 1'b1;
            acc_d = c;
          end
          else if (sample_valid)
          begin
            acc_d[0] = acc_q[0] + c[0];
            acc_d[1] = acc_q[1] + c[1];
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_IDLE;
      pcnt_q <= 16'h0000;
      acc_q <= '{32'h0, 32'h0};
      ae_q <= '{32'h0, 32'h0};
      pe_q <= '{32'h0, 32'h0};
      v_neg_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pcnt_q <= pcnt_d;
      acc_q <= acc_d;
      ae_q <= ae_d;
      pe_q <= pe_d;
      v_neg_q <= v_neg_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign cal_ready_flag = stat_q[STAT_CAL_READY_FLAG_BIT];
  assign zero_cross_flag = stat_q[STAT_ZX_BIT];
  assign sample_ready_flag = stat_q[STAT_WFS_BIT];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_raw_acc;
    state_q == ST_CAL_RUN && sample_valid && !zc && !ctrl_wr
      |=> acc_q[0] == $past(acc_q[0]) + $past(c[0]);
  endproperty
  a_raw_acc: assert property (p_raw_acc) else $error("cal accumulation wrong");

  property p_start_zc;
    $rose(state_q == ST_CAL_RUN) |-> $past(zc) && $past(state_q) == ST_CAL_WAIT;
  endproperty
  a_start_zc: assert property (p_start_zc) else $error("cal began off crossing");

  property p_store;
    state_q == ST_CAL_RUN && zc && cal_end && !ctrl_wr |=> ae_q[0] == $past(acc_q[0]);
  endproperty
  a_store: assert property (p_store) else $error("cal result not stored");

  property p_ready;
    $rose(state_q == ST_CAL_DONE) |-> cal_ready_flag;
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag missing");

  property p_gain;
    gain_q[0] == GAIN_UNITY && poff_q[0] == 32'h0
      |-> c[0] == voltage_sample * current_sample_ch1;
  endproperty
  a_gain: assert property (p_gain) else $error("unity gain changes product");

  // channel two runs at unity gain with a nonzero offset in the bench
  property p_offset;
    gain_q[1] == GAIN_UNITY
      |-> c[1] - poff_q[1] == voltage_sample * current_sample_ch2;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not per product");

  property p_period;
    state_q == ST_MEAS && zc && !ctrl_wr
      |=> pe_q[0] == ($past(acc_q[0]) <<< NORM_SHIFT);
  endproperty
  a_period: assert property (p_period) else $error("period energy wrong");

  property p_flags;
    state_q == ST_MEAS && zc && !ctrl_wr |=> zero_cross_flag && sample_ready_flag;
  endproperty
  a_flags: assert property (p_flags) else $error("period flags not set");

  property p_hold;
    state_q == ST_CAL_DONE ##1 state_q == ST_CAL_DONE |-> $stable(ae_q[0]) && $stable(ae_q[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("cal result changed");

  c_cal_done: cover property (state_q == ST_CAL_RUN ##1 state_q == ST_CAL_DONE);
  c_meas_period: cover property (state_q == ST_MEAS && zc);
  c_clear_race: cover property (ctrl_wr == 1'b0 && wr_pend_q && |set_flags);
endmodule

// file: mcs_pkg.sv
// constants and types shared by the meter calibration sequencer
package mcs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GAIN1 = 8'h08;
  localparam logic [7:0] ADDR_GAIN2 = 8'h0C;
  localparam logic [7:0] ADDR_POFF1 = 8'h10;
  localparam logic [7:0] ADDR_POFF2 = 8'h14;
  localparam logic [7:0] ADDR_CALCNT = 8'h18;
  localparam logic [7:0] ADDR_AE1 = 8'h1C;
  localparam logic [7:0] ADDR_AE2 = 8'h20;
  localparam logic [7:0] ADDR_PE1 = 8'h24;
  localparam logic [7:0] ADDR_PE2 = 8'h28;
  localparam logic [7:0] ADDR_STATE = 8'h2C;
  localparam int ADDR_W = 8;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CAL = 2'h1;
  localparam logic [1:0] MODE_MEAS = 2'h2;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_BIT = 2;
  localparam int STAT_CAL_READY_FLAG_BIT = 0;
  localparam int STAT_ZX_BIT = 1;
  localparam int STAT_WFS_BIT = 2;
  localparam int GAIN_SHIFT = 14;
  localparam int NORM_SHIFT = 4;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [31:0] POFF_RST = 32'h0000_0000;
  localparam logic [15:0] CALCNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_CAL_WAIT, ST_CAL_RUN, ST_CAL_DONE, ST_MEAS} mcs_state_t;
endpackage

// file: mcs_adc_model.sv
// sample source standing in for the adc front end of the meter
`timescale 1ns/1ps
module mcs_adc_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic signed [15:0] amp_v,
  input wire logic signed [15:0] amp_i1,
  input wire logic signed [15:0] amp_i2,
  output logic sample_valid,
  output logic signed [15:0] voltage_sample,
  output logic signed [15:0] current_sample_ch1,
  output logic signed [15:0] current_sample_ch2
);
  localparam int HALF = 8;
  logic [1:0] div_q;
  logic [4:0] idx_q;
  logic neg;
  logic signed [15:0] v, i1, i2;
  // currents follow the voltage sign so each channel's products keep one sign
  assign neg = idx_q >= 5'(HALF);
  assign v = neg ? -amp_v : amp_v;
  assign i1 = neg ? -amp_i1 : amp_i1;
  assign i2 = neg ? -amp_i2 : amp_i2;
  // between strobes the lines carry junk, not the last sample
  assign voltage_sample = sample_valid ? v : ~v;
  assign current_sample_ch1 = sample_valid ? i1 : ~i1;
  assign current_sample_ch2 = sample_valid ? i2 : ~i2;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 2'h0;
      idx_q <= 5'h00;
      sample_valid <= 1'b0;
    end
    else
    begin
      div_q <= run ? div_q + 2'h1 : 2'h0;
      sample_valid <= run && div_q == 2'h3;
      if (sample_valid)
        idx_q <= (idx_q == 5'(2 * HALF - 1)) ? 5'h00 : idx_q + 5'h01;
    end
  end
endmodule

// file: tb_mcs_top.sv
// self-checking bench for the meter calibration sequencer
`timescale 1ns/1ps
module tb_mcs_top;
  import mcs_pkg::*;
  localparam longint V = 100;
  localparam longint I1 = 300;
  localparam longint I2 = -200;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sample_valid, cal_ready_flag, zero_cross_flag, sample_ready_flag;
  logic signed [15:0] voltage_sample, current_sample_ch1, current_sample_ch2;
  int err_total, tests_run;

  mcs_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_valid, .voltage_sample,
    .current_sample_ch1, .current_sample_ch2, .cal_ready_flag, .zero_cross_flag,
    .sample_ready_flag);
  mcs_adc_model i_adc (.hclk, .hresetn, .run, .amp_v(16'h0064), .amp_i1(16'h012C),
    .amp_i2(16'hFF38), .sample_valid, .voltage_sample, .current_sample_ch1,
    .current_sample_ch2);

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // one full period is sixteen corrected products at calibration scale
  function automatic logic [31:0] per_period(longint i, logic [15:0] g, logic [31:0] off);
    return 32'(16 * (((V * i * longint'(g)) >>> 14) + longint'($signed(off))));
  endfunction

  task automatic chk_word(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(string nm, logic exp, logic got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk_word(nm, exp, x);
  endtask

  task automatic wait_flag(logic cal);
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while ((cal ? cal_ready_flag : sample_ready_flag) !== 1'b1 && n < 1000);
    chk_bit("flag wait", 1'b1, cal ? cal_ready_flag : sample_ready_flag);
  endtask

  task automatic test_reset();
    chk_bit("hresp", 1'b0, hresp);
    rd_chk("gain1 reset", ADDR_GAIN1, {16'h0000, GAIN_RST});
    chk_bit("hreadyout", 1'b1, hreadyout);
    // unity gain with zero offset leaves every product untouched
    wr(ADDR_GAIN1, {16'h0000, GAIN_UNITY});
    rd_chk("gain1 unity", ADDR_GAIN1, {16'h0000, GAIN_UNITY});
    rd_chk("calcnt reset", ADDR_CALCNT, {16'h0000, CALCNT_RST});
    wr(8'h40, 32'hA5A5_A5A5);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    wr(ADDR_AE1, 32'h1234_5678);
    rd_chk("ae1 read only", ADDR_AE1, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic test_meas(logic sel);
    wr(ADDR_GAIN1, 32'h0000_40C0);
    wr(ADDR_GAIN2, {16'h0000, GAIN_UNITY});
    wr(ADDR_POFF1, 32'hFFFF_FF93);
    wr(ADDR_POFF2, 32'h0000_0005);
    wr(ADDR_CTRL, {29'h0, sel, MODE_MEAS});
    run <= 1'b1;
    wr(ADDR_STATUS, 32'h0000_0007);
    wait_flag(1'b0);
    wr(ADDR_STATUS, 32'h0000_0004);
    rd_chk("status after clear", ADDR_STATUS, 32'h0000_0002);
    wait_flag(1'b0);
    chk_bit("zero cross", 1'b1, zero_cross_flag);
    rd_chk("pe1", ADDR_PE1, per_period(I1, 16'h40C0, 32'hFFFF_FF93) << 4);
    rd_chk("pe2", ADDR_PE2, sel ? per_period(I2, GAIN_UNITY, 32'h5) << 4 : 32'h0);
    $display("test meas done");
  endtask

  task automatic test_cal();
    logic [31:0] e1;
    e1 = 3 * per_period(I1, 16'h40C0, 32'hFFFF_FF93);
    wr(ADDR_CALCNT, 32'h0000_0003);
    // written mid-period on purpose: the partial period must not count
    wr(ADDR_CTRL, {29'h0, 1'b1, MODE_CAL});
    wr(ADDR_STATUS, 32'h0000_0007);
    chk_bit("cal ready early", 1'b0, cal_ready_flag);
    rd_chk("status cleared", ADDR_STATUS, 32'h0000_0000);
    wait_flag(1'b1);
    rd_chk("ae1", ADDR_AE1, e1);
    rd_chk("ae2", ADDR_AE2, 3 * per_period(I2, GAIN_UNITY, 32'h5));
    rd_chk("status cal", ADDR_STATUS, 32'h0000_0001);
    repeat (300) @(posedge hclk);
    rd_chk("ae1 held", ADDR_AE1, e1);
    // switching off parks the engine and clears the period count
    wr(ADDR_CTRL, {29'h0, 1'b0, MODE_OFF});
    rd_chk("state off", ADDR_STATE, {13'h0, 3'(ST_IDLE), 16'h0000});
    $display("test cal done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    results();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset();
    test_meas(1'b0);
    test_meas(1'b1);
    test_cal();
    results();
  end
endmodule
